/* File: bench/test_uamb_core.sv */
// self-checking bench for the address-match and baud-select slice
`timescale 1ns/100ps
`default_nettype none
module test_uamb_core;
  localparam logic [7:0] SC = uamb_pkg::IDX_SERIAL_CONTROL;
  localparam logic [7:0] SA = uamb_pkg::IDX_SLAVE_ADDRESS;
  localparam logic [7:0] SM = uamb_pkg::IDX_SLAVE_ADDR_MASK;
  localparam logic [7:0] ST = uamb_pkg::IDX_IRQ_STATUS;
  localparam logic [7:0] PC = uamb_pkg::IDX_POWER_CONTROL;
  localparam logic [7:0] BG = uamb_pkg::IDX_BAUD_GEN_CONTROL;
  logic clk_i = 0, reset_i = 1, avs_read_i = 0, avs_write_i = 0;
  logic [11:0] avs_address_i = 12'h000;
  logic [31:0] avs_writedata_i = 32'h0000_0000, avs_readdata_o;
  logic avs_waitrequest_o, rx_last_data_i, rx_stop_i, rx_stop_ok_i;
  logic rx_ninth_i, tx_bit8_end_i = 0, tx_stop_begin_i = 0;
  logic timer1_ovf_i = 0, timer2_ovf_i = 0, tx_tick_o, rx_tick_o;
  logic rx_enable_o, tx_ninth_bit_o, rx_done_flag_o, tx_done_flag_o, irq_o;
  logic [1:0] mode_o;
  logic go = 0, p_ninth = 0, p_ok = 0, p_busy, early, nb;
  logic [7:0] rx_byte_i, p_byte = 8'h00, rd, a, m, b, rl;
  int bad_count = 0, n_checks = 0, cycles = 0, seed = 32'he515, g;
  //////////////////////////////////////////////////////////////////////////
  uamb_core i_dut (.clk_i(clk_i), .reset_i(reset_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_byteenable_i(4'h1),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .rx_last_data_i(rx_last_data_i),
    .rx_stop_i(rx_stop_i), .rx_stop_ok_i(rx_stop_ok_i),
    .rx_byte_i(rx_byte_i), .rx_ninth_i(rx_ninth_i),
    .tx_bit8_end_i(tx_bit8_end_i), .tx_stop_begin_i(tx_stop_begin_i),
    .timer1_ovf_i(timer1_ovf_i), .timer2_ovf_i(timer2_ovf_i),
    .tx_tick_o(tx_tick_o), .rx_tick_o(rx_tick_o), .mode_o(mode_o),
    .rx_enable_o(rx_enable_o), .tx_ninth_bit_o(tx_ninth_bit_o),
    .rx_done_flag_o(rx_done_flag_o), .tx_done_flag_o(tx_done_flag_o),
    .irq_o(irq_o));
  uamb_peer i_peer (.clk_i(clk_i), .go_i(go), .byte_i(p_byte),
    .ninth_i(p_ninth), .ok_i(p_ok), .last_o(rx_last_data_i),
    .stop_o(rx_stop_i), .ok_o(rx_stop_ok_i), .byte_o(rx_byte_i),
    .ninth_o(rx_ninth_i), .busy_o(p_busy));
  //////////////////////////////////////////////////////////////////////////
  // clock and hang guard; reset is released in the main sequence
  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      bad_count++;
      $display("MISMATCH t=%0t run too long", $time);
      stop_test();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // expectations and comparisons
  function automatic logic hit(input logic [7:0] ad, mk, by);
    return (((by ^ ad) & mk) == 8'h00) || ((~by & (ad | mk)) == 8'h00);
  endfunction : hit
  task automatic chk8(input logic [7:0] got, exp, input string msg);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, exp, input string msg);
    chk8({7'h00, got}, {7'h00, exp}, msg);
  endtask : chk1
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] idx, wd);
    @(posedge clk_i);
    avs_address_i <= {2'b00, idx, 2'b00};
    avs_read_i <= ~w;
    avs_write_i <= w;
    avs_writedata_i <= {24'h00_0000, wd};
    // no own limit: only the bench's hang guard ends this wait
    do
      @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o[7:0];
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus
  // one received frame; early holds the flag just after the last data bit
  task automatic frame(input logic [7:0] fb, input logic fn, fo);
    int n;
    @(posedge clk_i);
    p_byte <= fb;
    p_ninth <= fn;
    p_ok <= fo;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    for (n = 0; n < 40 && rx_last_data_i !== 1'b1; n++) @(posedge clk_i);
    @(posedge clk_i);
    #1 early = rx_done_flag_o;
    repeat (6) @(posedge clk_i);
  endtask : frame
  // one timer overflow pulse and the ticks it should pass on
  task automatic tmr(input logic two, input logic [3:0] s);
    @(posedge clk_i);
    timer1_ovf_i <= ~two;
    timer2_ovf_i <= two;
    @(posedge clk_i);
    timer1_ovf_i <= 1'b0;
    timer2_ovf_i <= 1'b0;
    #1 chk1(tx_tick_o, !s[1] && (s[0] == two), "tx source");
    chk1(rx_tick_o, !s[3] && (s[2] == two), "rx source");
  endtask : tmr
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    bus(0, SA, 0);
    chk8(rd, 8'h00, "address reset");
    bus(0, SM, 0);
    chk8(rd, 8'h00, "mask reset");
    bus(1, 8'h10, 8'h5A);
    bus(0, 8'h10, 0);
    chk8(rd, 8'h00, "unmapped read");
    bus(1, uamb_pkg::IDX_IRQ_MASK, 8'h07);
    $display("test reset done");
    for (int k = 0; k < 4; k++)
    begin
      bus(1, SC, {k[1:0], 1'b0, ~k[0], k[0], 3'b000});
      @(posedge clk_i);
      #1 chk8({6'h00, mode_o}, k[7:0], "mode");
      chk8({6'h00, rx_enable_o, tx_ninth_bit_o},
        {6'h00, ~k[0], k[0]}, "ren tb8");
      @(posedge clk_i);
      tx_bit8_end_i <= (k == 0);
      tx_stop_begin_i <= (k != 0);
      @(posedge clk_i);
      tx_bit8_end_i <= 1'b0;
      tx_stop_begin_i <= 1'b0;
      @(posedge clk_i);
      #1 chk1(tx_done_flag_o, 1'b1, "tx flag");
    end
    bus(1, SC, 8'h10);
    frame(8'hA5, 1'b0, 1'b1);
    chk1(early, 1'b1, "shift rx flag");
    $display("test modes done");
    for (int s = 0; s < 16; s++)
    begin
      bus(1, uamb_pkg::IDX_TIMER2_CONTROL, {2'b00, s[2], s[0], 4'h0});
      bus(1, BG, {4'h0, s[1], s[3], 2'b00});
      tmr(1'b0, s[3:0]);
      tmr(1'b1, s[3:0]);
    end
    $display("test clock select done");
    for (int i = 0; i < 4; i++)
    begin
      rl = $random(seed);
      rl[7:3] = (i == 0) ? 5'h1F : 5'h1E;
      nb = $random(seed);
      a = $random(seed);
      bus(1, uamb_pkg::IDX_BAUD_RELOAD, rl);
      bus(1, PC, {nb, 7'h00});
      bus(1, BG, {3'h0, 2'b11, 1'b0, a[0], 1'b0});
      for (int j = 0; j < 2; j++)
      begin
        g = 0;
        do
        begin
          @(posedge clk_i);
          g++;
        end
        while (tx_tick_o !== 1'b1 && g < 4000);
      end
      chk8(g[7:0], ((a[0] ? 1 : 6) * (256 - rl) * (nb ? 16 : 32)) % 256,
        "baud period");
    end
    bus(1, BG, 8'h00);
    bus(1, PC, 8'h00);
    $display("test baud done");
    bus(1, SC, 8'hF0);
    bus(1, ST, 8'h07);
    for (int i = 0; i < 12; i++)
    begin
      case (i)
        0: {a, m} = 16'h0000;
        1: {a, m} = 16'h56FC;
        2: {a, m} = 16'hF1FA;
        3: {a, m} = 16'hF3F9;
        4: {a, m} = 16'hF3FD;
        default: {a, m} = $random(seed);
      endcase
      bus(1, SA, a);
      bus(1, SM, m);
      for (int j = 0; j < 4; j++)
      begin
        b = $random(seed);
        nb = (j == 3) ? b[7] : 1'b1;
        if (j == 0) b = 8'hFF;
        if (j == 1) b = 8'hFB;
        if (j == 2) b = a ^ (b & ~m);
        frame(b, nb, 1'b1);
        nb = nb & hit(a, m, b);
        chk1(rx_done_flag_o, nb, "address");
        chk1(irq_o, nb, "rx irq");
        bus(1, SC, 8'hF0);
        bus(1, ST, 8'h07);
        bus(0, ST, 0);
        chk8(rd, 8'h00, "status cleared");
      end
    end
    $display("test address done");
    bus(1, SA, 8'h00);
    bus(1, SM, 8'h00);
    bus(1, uamb_pkg::IDX_IRQ_MASK, 8'h00);
    bus(1, SC, 8'h70);
    frame(8'h3C, 1'b1, 1'b0);
    chk1(rx_done_flag_o, 1'b0, "bad stop address");
    frame(8'h3C, 1'b0, 1'b1);
    chk1(rx_done_flag_o, 1'b1, "good stop address");
    chk1(irq_o, 1'b0, "masked irq");
    bus(0, ST, 0);
    chk8(rd & 8'h01, 8'h01, "rx status");
    $display("test stop bit done");
    bus(1, SC, 8'hD0);
    bus(0, SC, 0);
    chk1(rd[7], 1'b1, "bit7 is mode");
    bus(1, PC, 8'h40);
    bus(0, SC, 0);
    chk1(rd[7], 1'b0, "bit7 is error");
    frame(8'h81, 1'b1, 1'b0);
    chk1(early, 1'b0, "flag waits for stop");
    chk1(rx_done_flag_o, 1'b1, "flag on stop");
    bus(1, SC, 8'hD0);
    frame(8'h18, 1'b1, 1'b1);
    bus(0, SC, 0);
    chk1(rd[7], 1'b1, "error sticky");
    chk1(rd[2], 1'b1, "ninth bit kept");
    bus(1, SC, 8'h50);
    bus(0, SC, 0);
    chk1(rd[7], 1'b0, "error cleared");
    bus(1, PC, 8'h00);
    bus(0, SC, 0);
    chk1(rd[7], 1'b1, "mode kept");
    $display("test framing done");
    stop_test();
  end
endmodule : test_uamb_core
`default_nettype wire

/* File: bench/uamb_peer.sv */
// far-side processor model that feeds received frame strobes
`timescale 1ns/100ps
`default_nettype none
module uamb_peer
(
  // clock and command from the bench
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [7:0] byte_i,
  input  wire logic       ninth_i,
  input  wire logic       ok_i,
  // frame strobes toward the receiver
  output logic            last_o,
  output logic            stop_o,
  output logic            ok_o,
  output logic      [7:0] byte_o,
  output logic            ninth_o,
  output logic            busy_o
);
  logic [3:0] cnt = 4'h0;
  logic [7:0] noise = 8'h00;
  logic [7:0] held = 8'h00;
  logic       held_n = 1'b0;
  logic       held_ok = 1'b0;
  //////////////////////////////////////////////////////////////////////////
  // bit-time counter; noise changes every cycle so stale data never holds
  always_ff @(posedge clk_i)
  begin
    noise <= noise + 8'h5b;
    cnt   <= (cnt == 4'h0) ? {3'h0, go_i}
           : ((cnt == 4'hB) ? 4'h0 : cnt + 4'h1);
    if (go_i && cnt == 4'h0)
    begin
      held    <= byte_i;
      held_n  <= ninth_i;
      held_ok <= ok_i;
    end
  end
  // strobes and qualified data
  assign last_o  = (cnt == 4'h9);
  assign stop_o  = (cnt == 4'hB);
  assign busy_o  = (cnt != 4'h0);
  assign byte_o  = (last_o | stop_o) ? held : noise;
  assign ninth_o = (last_o | stop_o) ? held_n : noise[0];
  assign ok_o    = stop_o ? held_ok : noise[1];
endmodule : uamb_peer
`default_nettype wire

/* File: logic/uamb_core.sv */
// serial address recognition, baud source selection and control flags
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
module uamb_core
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // avalon-mm slave
  input  wire logic [11:0] avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [3:0]  avs_byteenable_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // frame engine strobes
  input  wire logic        rx_last_data_i,
  input  wire logic        rx_stop_i,
  input  wire logic        rx_stop_ok_i,
  input  wire logic [7:0]  rx_byte_i,
  input  wire logic        rx_ninth_i,
  input  wire logic        tx_bit8_end_i,
  input  wire logic        tx_stop_begin_i,
  // timer overflows
  input  wire logic        timer1_ovf_i,
  input  wire logic        timer2_ovf_i,
  // serial controls and flags
  output logic             tx_tick_o,
  output logic             rx_tick_o,
  output logic      [1:0]  mode_o,
  output logic             rx_enable_o,
  output logic             tx_ninth_bit_o,
  output logic             rx_done_flag_o,
  output logic             tx_done_flag_o,
  output logic             irq_o
);
  ////////////////////////////////////////////////////////////////////////
  // register state
  logic                  mode_bit_zero;
  logic                  multiproc_enable;
  logic                  rx_ninth_bit;
  logic                  framing_error_flag;
  logic [7:0]            slave_address;
  logic [7:0]            slave_address_mask;
  logic [7:0]            baud_reload;
  logic                  brg_run;
  logic                  brg_tx_clock_sel;
  logic                  brg_rx_clock_sel;
  logic                  speed_bit;
  logic                  timer2_tx_clock_sel;
  logic                  timer2_rx_clock_sel;
  logic                  double_bit;
  logic                  framing_enable;
  logic [2:0]            irq_status;
  logic [2:0]            irq_mask;
  logic [2:0]            pre_cnt;
  logic [7:0]            brg_cnt;
  logic                  brg_ovf;
  logic [4:0]            div_cnt;

  ////////////////////////////////////////////////////////////////////////
  // bus decode; one wait cycle, then the answer
  wire       bus_req = avs_read_i | avs_write_i;
  wire [7:0] idx = avs_address_i[9:2];
  wire       in_map = avs_address_i[11:10] == 2'b00;
  wire       wr = avs_write_i & ~avs_waitrequest_o & in_map
                  & avs_byteenable_i[0];
  wire [7:0] wd = avs_writedata_i[7:0];
  wire       wr_sc = wr & (idx == uamb_pkg::IDX_SERIAL_CONTROL);
  wire       wr_sa = wr & (idx == uamb_pkg::IDX_SLAVE_ADDRESS);
  wire       wr_sm = wr & (idx == uamb_pkg::IDX_SLAVE_ADDR_MASK);
  wire       wr_br = wr & (idx == uamb_pkg::IDX_BAUD_RELOAD);
  wire       wr_bg = wr & (idx == uamb_pkg::IDX_BAUD_GEN_CONTROL);
  wire       wr_t2 = wr & (idx == uamb_pkg::IDX_TIMER2_CONTROL);
  wire       wr_pc = wr & (idx == uamb_pkg::IDX_POWER_CONTROL);
  wire       wr_is = wr & (idx == uamb_pkg::IDX_IRQ_STATUS);
  wire       wr_im = wr & (idx == uamb_pkg::IDX_IRQ_MASK);

  ////////////////////////////////////////////////////////////////////////
  // mode decode
  uamb_pkg::uamb_mode_type mode;
  assign mode = uamb_pkg::uamb_mode_type'(mode_o);
  wire shift_mode = mode == uamb_pkg::MODE_SHIFT;
  wire mode_8var = mode == uamb_pkg::MODE_UART8_VAR;
  wire mp_live = multiproc_enable & ~shift_mode;

  ////////////////////////////////////////////////////////////////////////
  // address recognition
  wire [7:0] bcast_addr = slave_address | slave_address_mask;
  wire given_hit =
    ((rx_byte_i ^ slave_address) & slave_address_mask) == 8'h00;
  wire bcast_hit = (~rx_byte_i & bcast_addr) == 8'h00;
  wire addr_hit = given_hit | bcast_hit;

  ////////////////////////////////////////////////////////////////////////
  // receive and transmit flag events
  wire on_stop = ~shift_mode & (framing_enable | (mode_8var & mp_live));
  wire rx_strobe = on_stop ? rx_stop_i : rx_last_data_i;
  wire rx_accept = ~mp_live ? 1'b1
                 : mode_8var ? (rx_stop_ok_i & addr_hit)
                 : (rx_ninth_i & addr_hit);
  wire rx_set = rx_strobe & rx_accept;
  wire tx_set = shift_mode ? tx_bit8_end_i : tx_stop_begin_i;
  wire fe_set = rx_stop_i & ~rx_stop_ok_i & framing_enable & ~shift_mode;
  wire fe_clr = wr_sc & framing_enable & ~wd[uamb_pkg::SC_BIT7];

  ////////////////////////////////////////////////////////////////////////
  // control register read view; bit 7 depends on framing enable
  wire bit7_view = framing_enable ? framing_error_flag
                                  : mode_bit_zero;
  wire [7:0] sc_view = {bit7_view, mode_o[0], multiproc_enable,
                        rx_enable_o, tx_ninth_bit_o, rx_ninth_bit,
                        tx_done_flag_o, rx_done_flag_o};
  wire [7:0] bg_view = {3'b000, brg_run, brg_tx_clock_sel,
                        brg_rx_clock_sel, speed_bit, 1'b0};
  wire [7:0] t2_view = {2'b00, timer2_rx_clock_sel,
                        timer2_tx_clock_sel, 4'h0};
  wire [7:0] pc_view = {double_bit, framing_enable, 6'h00};
  wire [7:0] rd_val =
      ~in_map ? 8'h00
    : idx == uamb_pkg::IDX_SERIAL_CONTROL ? sc_view
    : idx == uamb_pkg::IDX_SLAVE_ADDRESS ? slave_address
    : idx == uamb_pkg::IDX_SLAVE_ADDR_MASK ? slave_address_mask
    : idx == uamb_pkg::IDX_BAUD_RELOAD ? baud_reload
    : idx == uamb_pkg::IDX_BAUD_GEN_CONTROL ? bg_view
    : idx == uamb_pkg::IDX_TIMER2_CONTROL ? t2_view
    : idx == uamb_pkg::IDX_POWER_CONTROL ? pc_view
    : idx == uamb_pkg::IDX_IRQ_STATUS ? {5'h00, irq_status}
    : idx == uamb_pkg::IDX_IRQ_MASK ? {5'h00, irq_mask}
    : 8'h00;

  // bus handshake and read data
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end
    else
    begin
      avs_waitrequest_o <= ~(bus_req & avs_waitrequest_o);
      if (bus_req & avs_waitrequest_o)
        avs_readdata_o <= {24'h00_0000, rd_val};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address and mask registers
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      slave_address <= uamb_pkg::RST_BYTE;
      slave_address_mask <= uamb_pkg::RST_BYTE;
    end
    else
    begin
      if (wr_sa)
        slave_address <= wd;
      if (wr_sm)
        slave_address_mask <= wd;
    end
  end

  // serial control bits
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      mode_bit_zero <= 1'b0;
      mode_o <= 2'b00;
      multiproc_enable <= 1'b0;
      rx_enable_o <= 1'b0;
      tx_ninth_bit_o <= 1'b0;
    end
    else if (wr_sc)
    begin
      if (~framing_enable)
        mode_bit_zero <= wd[uamb_pkg::SC_BIT7];
      mode_o <= {framing_enable ? mode_bit_zero : wd[uamb_pkg::SC_BIT7],
                 wd[uamb_pkg::SC_MODE1]};
      multiproc_enable <= wd[uamb_pkg::SC_MP];
      rx_enable_o <= wd[uamb_pkg::SC_REN];
      tx_ninth_bit_o <= wd[uamb_pkg::SC_TB8];
    end
  end

  // hardware flags; a hardware set wins over a software write
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rx_done_flag_o <= 1'b0;
      tx_done_flag_o <= 1'b0;
      rx_ninth_bit <= 1'b0;
      framing_error_flag <= 1'b0;
    end
    else
    begin
      if (rx_set)
        rx_done_flag_o <= 1'b1;
      else if (wr_sc)
        rx_done_flag_o <= wd[uamb_pkg::SC_RI];
      if (tx_set)
        tx_done_flag_o <= 1'b1;
      else if (wr_sc)
        tx_done_flag_o <= wd[uamb_pkg::SC_TI];
      if (rx_set & ~shift_mode)
        rx_ninth_bit <= mode_8var ? rx_stop_ok_i : rx_ninth_i;
      else if (wr_sc)
        rx_ninth_bit <= wd[uamb_pkg::SC_RB8];
      if (fe_set)
        framing_error_flag <= 1'b1;
      else if (fe_clr)
        framing_error_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // baud, timer and power control bits
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      baud_reload <= uamb_pkg::RST_BYTE;
      {brg_run, brg_tx_clock_sel, brg_rx_clock_sel, speed_bit} <= 4'h0;
      {timer2_tx_clock_sel, timer2_rx_clock_sel} <= 2'b00;
      {double_bit, framing_enable} <= 2'b00;
    end
    else
    begin
      if (wr_br)
        baud_reload <= wd;
      if (wr_bg)
      begin
        brg_run <= wd[uamb_pkg::BG_RUN];
        brg_tx_clock_sel <= wd[uamb_pkg::BG_BRG_TX_CLOCK_SEL];
        brg_rx_clock_sel <= wd[uamb_pkg::BG_BRG_RX_CLOCK_SEL];
        speed_bit <= wd[uamb_pkg::BG_SPD];
      end
      if (wr_t2)
      begin
        timer2_tx_clock_sel <= wd[uamb_pkg::T2_TIMER2_TX_CLOCK_SEL];
        timer2_rx_clock_sel <= wd[uamb_pkg::T2_RCLK];
      end
      if (wr_pc)
      begin
        double_bit <= wd[uamb_pkg::PC_DOUBLE];
        framing_enable <= wd[uamb_pkg::PC_FRAMING];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // internal baud generator: prescale, reload counter, final divide
  wire pre_tick = speed_bit | (pre_cnt == uamb_pkg::PRE_LAST);
  wire brg_wrap = brg_run & pre_tick & (brg_cnt == uamb_pkg::BRG_TOP);
  wire brg_tick = brg_ovf & (double_bit
                  ? div_cnt[3:0] == uamb_pkg::DIV_LAST_X2
                  : div_cnt == uamb_pkg::DIV_LAST);

  always_ff @(posedge clk_i)
  begin
    if (reset_i | ~brg_run)
    begin
      pre_cnt <= 3'h0;
      brg_cnt <= baud_reload;
      brg_ovf <= 1'b0;
      div_cnt <= 5'h00;
    end
    else
    begin
      pre_cnt <= pre_tick ? 3'h0 : pre_cnt + 3'h1;
      brg_ovf <= brg_wrap;
      if (pre_tick)
        brg_cnt <= brg_wrap ? baud_reload : brg_cnt + 8'h01;
      if (brg_ovf)
        div_cnt <= brg_tick ? 5'h00 : div_cnt + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-direction clock source selection
  uamb_pkg::uamb_src_type tx_src;
  uamb_pkg::uamb_src_type rx_src;
  assign tx_src = brg_tx_clock_sel ? uamb_pkg::SRC_BRG
                : timer2_tx_clock_sel ? uamb_pkg::SRC_T2
                : uamb_pkg::SRC_T1;
  assign rx_src = brg_rx_clock_sel ? uamb_pkg::SRC_BRG
                : timer2_rx_clock_sel ? uamb_pkg::SRC_T2
                : uamb_pkg::SRC_T1;
  wire tx_pick = tx_src == uamb_pkg::SRC_BRG ? brg_tick
               : tx_src == uamb_pkg::SRC_T2 ? timer2_ovf_i
               : timer1_ovf_i;
  wire rx_pick = rx_src == uamb_pkg::SRC_BRG ? brg_tick
               : rx_src == uamb_pkg::SRC_T2 ? timer2_ovf_i
               : timer1_ovf_i;

  // interrupt status, mask and output
  wire [2:0] irq_ev = {fe_set, tx_set, rx_set};
  wire [2:0] irq_w1c = wr_is ? wd[2:0] : 3'b000;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      tx_tick_o <= 1'b0;
      rx_tick_o <= 1'b0;
      irq_status <= 3'b000;
      irq_mask <= 3'b000;
      irq_o <= 1'b0;
    end
    else
    begin
      tx_tick_o <= tx_pick;
      rx_tick_o <= rx_pick;
      irq_status <= (irq_status & ~irq_w1c) | irq_ev;
      if (wr_im)
        irq_mask <= wd[2:0];
      irq_o <= |(irq_status & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_reset_accepts_any: assert property (
    $fell(reset_i) |-> slave_address == 8'h00
      && slave_address_mask == 8'h00)
    else $error("address registers not cleared by reset");
  a_bcast_match: assert property (
    rx_byte_i == (slave_address | slave_address_mask) |-> addr_hit)
    else $error("broadcast address not matched");
  a_mp_reject_data: assert property (
    mp_live && !mode_8var && !on_stop && rx_last_data_i && !rx_ninth_i
      && !rx_done_flag_o && !wr_sc |=> !rx_done_flag_o)
    else $error("data frame flagged in multiprocessor mode");
  a_mode1_bad_stop: assert property (
    mp_live && mode_8var && rx_stop_i && !rx_stop_ok_i
      && !rx_done_flag_o && !wr_sc |=> !rx_done_flag_o)
    else $error("frame with bad stop flagged");
  a_tx_brg_sel: assert property (
    brg_tx_clock_sel && brg_tick |=> tx_tick_o)
    else $error("transmit tick not from baud generator");
  a_rx_t2_sel: assert property (
    !brg_rx_clock_sel && timer2_rx_clock_sel
      && (timer2_ovf_i != timer1_ovf_i) |=> rx_tick_o == $past(timer2_ovf_i))
    else $error("receive tick not from timer 2");
  a_brg_reload: assert property (
    brg_wrap && !wr_br && !wr_bg |=> brg_ovf && brg_cnt == baud_reload)
    else $error("baud generator did not reload");
  a_fe_sticky: assert property (
    framing_error_flag && !fe_clr |=> framing_error_flag)
    else $error("framing error cleared without software");
  a_fe_set: assert property (
    fe_set |=> framing_error_flag ##1 irq_status[uamb_pkg::IRQ_FE])
    else $error("invalid stop did not set framing error");
  a_shift_rx_flag: assert property (
    shift_mode && rx_last_data_i |=> rx_done_flag_o)
    else $error("receive flag not set in shift mode");
  a_fe_stop_only: assert property (
    framing_enable && !shift_mode && rx_last_data_i && !rx_stop_i
      && !rx_done_flag_o && !wr_sc |=> !rx_done_flag_o)
    else $error("receive flag rose before stop bit");
  a_tx_flag_set: assert property (
    tx_set |=> tx_done_flag_o ##1 irq_status[uamb_pkg::IRQ_TX])
    else $error("transmit flag not set");
endmodule : uamb_core
`default_nettype wire

/* File: shared/uamb_pkg.sv */
// constants and types for the serial address-match and baud-select slice
// Operation
// - broadcast address is slave address OR mask; zero bits are don't-care
// - given address is slave address; mask zero bits are don't-care
// - reset clears address and mask so every address is accepted
// - multiprocessor mode: address frame flags receive only on address match
// - 8-bit variable mode uses stop bit as ninth; needs match and valid stop
// - transmit clock: baud generator, else timer 2, else timer 1
// - receive clock: baud generator, else timer 2, else timer 1
// - baud generator reloads on overflow; rate set by double, speed, reload
// - control bit 7 is framing error when framing enabled, else mode bit 0
// - invalid stop sets framing error; only software write or reset clears
// - mode 01 is 8-bit variable, mode 10 is 9-bit fixed rate
// - multiprocessor enable acts in 9-bit modes and 8-bit variable mode
// - receive flag set at eighth bit end in shift mode; software clears
// - with framing detection, outside shift mode, the receive flag rises on the stop bit
`default_nettype none
package uamb_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_POWER_CONTROL     = 8'h87;
  localparam logic [7:0] IDX_SERIAL_CONTROL    = 8'h98;
  localparam logic [7:0] IDX_BAUD_RELOAD       = 8'h9A;
  localparam logic [7:0] IDX_BAUD_GEN_CONTROL  = 8'h9B;
  localparam logic [7:0] IDX_SLAVE_ADDRESS     = 8'hA9;
  localparam logic [7:0] IDX_SLAVE_ADDR_MASK   = 8'hB9;
  localparam logic [7:0] IDX_TIMER2_CONTROL    = 8'hC8;
  localparam logic [7:0] IDX_IRQ_STATUS        = 8'hF0;
  localparam logic [7:0] IDX_IRQ_MASK          = 8'hF1;
  // serial_control fields
  localparam int SC_BIT7 = 7;
  localparam int SC_MODE1 = 6;
  localparam int SC_MP = 5;
  localparam int SC_REN = 4;
  localparam int SC_TB8 = 3;
  localparam int SC_RB8 = 2;
  localparam int SC_TI = 1;
  localparam int SC_RI = 0;
  // timer2_control, baud_gen_control and power_control fields
  localparam int T2_RCLK = 5;
  localparam int T2_TIMER2_TX_CLOCK_SEL = 4;
  localparam int BG_RUN = 4;
  localparam int BG_BRG_TX_CLOCK_SEL = 3;
  localparam int BG_BRG_RX_CLOCK_SEL = 2;
  localparam int BG_SPD = 1;
  localparam int PC_DOUBLE = 7;
  localparam int PC_FRAMING = 6;
  // interrupt status fields
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  localparam int IRQ_FE = 2;
  // reset values and counts
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] PRE_LAST = 3'h5;    // slow prescale of 6
  localparam logic [7:0] BRG_TOP = 8'hFF;    // counter wraps at 256
  localparam logic [4:0] DIV_LAST = 5'h1F;   // divide by 32
  localparam logic [3:0] DIV_LAST_X2 = 4'hF; // divide by 16
  // serial modes and clock sources
  typedef enum logic [1:0]
  {
    MODE_SHIFT, MODE_UART8_VAR, MODE_UART9_FIX, MODE_UART9_VAR
  } uamb_mode_type;
  typedef enum logic [1:0] {SRC_T1, SRC_T2, SRC_BRG} uamb_src_type;
endpackage : uamb_pkg
`default_nettype wire
